// ==== rtl/axs_irq.sv ====
`timescale 1ns/1ps
`default_nettype none

// Sticky cause bits, write-one-to-clear, enable-gated level interrupt.
module axs_irq
    import axs_pkg::*;
#(
    parameter int WIDTH = AXS_IRQ_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] event_i,
    input wire logic [WIDTH-1:0] clear_i,
    input wire logic [WIDTH-1:0] enable_i,
    output logic [WIDTH-1:0] status_o,
    output logic irq_o
);

    // The cause layout needs every bit up to the last comparator.
    if (WIDTH < AXS_IRQ_W) begin : g_width_check
        $error("axs_irq: WIDTH too small for the cause layout.");
    end

    logic [WIDTH-1:0] status_ff;
    logic irq_ff;
    wire [WIDTH-1:0] nxt_status;
    wire nxt_irq;

    // A new event wins over a clear in the same cycle.
    assign nxt_status = (status_ff & ~clear_i) | event_i;
    // The line rises on the edge that latches the cause.
    assign nxt_irq = |(nxt_status & enable_i);

    // Cause and interrupt flip-flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq_ff <= nxt_irq;
        end
    end

    assign status_o = status_ff;
    assign irq_o = irq_ff;

endmodule

`default_nettype wire

// ==== rtl/axs_pkg.sv ====
package axs_pkg;

    // Register byte addresses on the Wishbone slave.
    localparam logic [7:0] AXS_ADR_ENV2 = 8'h00;
    localparam logic [7:0] AXS_ADR_ENV5 = 8'h04;
    localparam logic [7:0] AXS_ADR_MODE = 8'h08;
    localparam logic [7:0] AXS_ADR_CMD = 8'h0c;
    localparam logic [7:0] AXS_ADR_EXT_STS = 8'h10;
    localparam logic [7:0] AXS_ADR_IRQ_STS = 8'h14;
    localparam logic [7:0] AXS_ADR_IRQ_CLR = 8'h18;
    localparam logic [7:0] AXS_ADR_IRQ_EN = 8'h1c;

    // Register reset values.
    localparam logic [31:0] AXS_RST_WORD = 32'h0000_0000;

    // Field positions.
    localparam int AXS_SMODE_BIT = 29;
    localparam int AXS_SYO_LSB = 16;
    localparam int AXS_SYI_LSB = 20;
    localparam int AXS_MSY_LSB = 18;
    localparam int AXS_MAX_LSB = 20;
    localparam int AXS_CMD_START_BIT = 0;
    localparam int AXS_CMD_STOP_BIT = 1;

    // Output timing codes.
    localparam logic [3:0] AXS_SYO_CMP1 = 4'h1;
    localparam logic [3:0] AXS_SYO_CMP2 = 4'h2;
    localparam logic [3:0] AXS_SYO_CMP3 = 4'h3;
    localparam logic [3:0] AXS_SYO_CMP4 = 4'h4;
    localparam logic [3:0] AXS_SYO_CMP5 = 4'h5;
    localparam logic [3:0] AXS_SYO_ACC_START = 4'h8;
    localparam logic [3:0] AXS_SYO_ACC_DONE = 4'h9;
    localparam logic [3:0] AXS_SYO_DEC_START = 4'ha;
    localparam logic [3:0] AXS_SYO_DEC_DONE = 4'hb;

    // Input select, start method and stop axis codes.
    localparam logic [1:0] AXS_SYI_X = 2'h0;
    localparam logic [1:0] AXS_SYI_Y = 2'h1;
    localparam logic [1:0] AXS_MSY_SYNC = 2'h2;
    localparam logic [1:0] AXS_MSY_STOP = 2'h3;
    localparam logic [1:0] AXS_MAX_X = 2'h1;
    localparam logic [1:0] AXS_MAX_Y = 2'h2;
    localparam logic [1:0] AXS_MAX_XY = 2'h3;

    // Operation status codes.
    localparam logic [3:0] AXS_ST_IDLE = 4'h0;
    localparam logic [3:0] AXS_ST_RUN = 4'h1;
    localparam logic [3:0] AXS_ST_WSYNC = 4'h3;
    localparam logic [3:0] AXS_ST_WSTOP = 4'h4;

    // Interrupt cause layout: bits 4 to 12 are events, the rest read zero.
    localparam int AXS_IRQ_W = 13;
    localparam logic [12:0] AXS_IRQ_MASK = 13'h1ff0;

    // Motion and comparator events of this axis, one-cycle pulses.
    typedef struct packed {
        logic [4:0] cmp_hit;
        logic decel_done;
        logic decel_start;
        logic accel_done;
        logic accel_start;
    } axs_evt_t;

    // Levels and pulses seen from both axes of the controller.
    typedef struct packed {
        logic x_stopped;
        logic y_stopped;
        logic x_sync;
        logic y_sync;
    } axs_axes_t;

    typedef enum logic [1:0] {
        AXS_IDLE,
        AXS_WAIT_SYNC,
        AXS_WAIT_STOP,
        AXS_RUN
    } axs_state_t;

endpackage

// ==== rtl/axs_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module axs_top
    import axs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire axs_evt_t evt_i,
    input wire axs_axes_t axes_i,
    output logic run_o,
    output logic sync_o,
    output logic irq_o
);

    // The decoder needs room for every register address.
    if (ADDR_W < 8) begin : g_addr_check
        $error("axs_top: ADDR_W must be at least 8.");
    end

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Selects the trigger of the internal sync pulse from the timing code.
    function automatic logic sync_trigger(
        input logic [3:0] code,
        input axs_evt_t ev
    );
        logic hit;
        hit = 1'b0;
        case (code)
            AXS_SYO_CMP1: hit = ev.cmp_hit[0];
            AXS_SYO_CMP2: hit = ev.cmp_hit[1];
            AXS_SYO_CMP3: hit = ev.cmp_hit[2];
            AXS_SYO_CMP4: hit = ev.cmp_hit[3];
            AXS_SYO_CMP5: hit = ev.cmp_hit[4];
            AXS_SYO_ACC_START: hit = ev.accel_start;
            AXS_SYO_ACC_DONE: hit = ev.accel_done;
            AXS_SYO_DEC_START: hit = ev.decel_start;
            AXS_SYO_DEC_DONE: hit = ev.decel_done;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Whether the monitored axis or axes are stopped for a stop code.
    function automatic logic stop_met(
        input logic [1:0] code,
        input axs_axes_t ax
    );
        logic met;
        met = 1'b0;
        case (code)
            AXS_MAX_X: met = ax.x_stopped;
            AXS_MAX_Y: met = ax.y_stopped;
            AXS_MAX_XY: met = ax.x_stopped & ax.y_stopped;
            default: met = 1'b0;
        endcase
        return met;
    endfunction

    // Software-visible storage.
    logic [31:0] env2_ff;
    logic [31:0] env5_ff;
    logic [31:0] mode_ff;
    logic [AXS_IRQ_W-1:0] irq_en_ff;
    logic [31:0] dat_ff;
    logic ack_ff;

    // Axis state and outputs.
    axs_state_t state_ff;
    axs_state_t nxt_state;
    logic run_ff;
    logic sync_ff;
    logic stop_prev_ff;

    // Interrupt block outputs.
    logic [AXS_IRQ_W-1:0] irq_sts;
    logic irq_line;

    // Bus request decode: a new request is taken while ack is low.
    wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire wr = req & wb_we_i;
    wire rd = req & ~wb_we_i;
    wire [7:0] adr = wb_adr_i[7:0];
    wire hi_ok = (ADDR_W == 8) ? 1'b1 : ~|(wb_adr_i >> 8);
    wire wr_env2 = wr & hi_ok & (adr == AXS_ADR_ENV2);
    wire wr_env5 = wr & hi_ok & (adr == AXS_ADR_ENV5);
    wire wr_mode = wr & hi_ok & (adr == AXS_ADR_MODE);
    wire wr_cmd = wr & hi_ok & (adr == AXS_ADR_CMD);
    wire wr_clr = wr & hi_ok & (adr == AXS_ADR_IRQ_CLR);
    wire wr_en = wr & hi_ok & (adr == AXS_ADR_IRQ_EN);

    // Merged write words.
    wire [31:0] env2_wr = merge_lanes(env2_ff, wb_dat_i, wb_sel_i);
    wire [31:0] env5_wr = merge_lanes(env5_ff, wb_dat_i, wb_sel_i);
    wire [31:0] mode_wr = merge_lanes(mode_ff, wb_dat_i, wb_sel_i);
    wire [31:0] en_old = {{(32 - AXS_IRQ_W){1'b0}}, irq_en_ff};
    wire [31:0] en_wr = merge_lanes(en_old, wb_dat_i, wb_sel_i);
    wire [31:0] clr_wr = merge_lanes(32'h0000_0000, wb_dat_i, wb_sel_i);

    // Command strobes, one cycle long, bits in the low byte lane.
    wire start_cmd = wr_cmd & wb_sel_i[0] & wb_dat_i[AXS_CMD_START_BIT];
    wire stop_cmd = wr_cmd & wb_sel_i[0] & wb_dat_i[AXS_CMD_STOP_BIT];

    // Clear pulses and enables confined to the cause layout.
    wire [AXS_IRQ_W-1:0] clr_bits = wr_clr ?
        (clr_wr[AXS_IRQ_W-1:0] & AXS_IRQ_MASK) : '0;
    wire [AXS_IRQ_W-1:0] nxt_irq_en = wr_en ?
        (en_wr[AXS_IRQ_W-1:0] & AXS_IRQ_MASK) : irq_en_ff;

    // Configuration fields.
    wire enhanced = env2_ff[AXS_SMODE_BIT];
    wire [3:0] syo_code = env5_ff[AXS_SYO_LSB +: 4];
    wire [1:0] syi_code = env5_ff[AXS_SYI_LSB +: 2];
    wire [1:0] msy_code = mode_ff[AXS_MSY_LSB +: 2];
    wire [1:0] max_code = mode_ff[AXS_MAX_LSB +: 2];

    // Selected incoming sync pulse; other codes listen to nothing.
    wire sync_in = (syi_code == AXS_SYI_X) ? axes_i.x_sync :
        (syi_code == AXS_SYI_Y) ? axes_i.y_sync : 1'b0;

    // Stop condition: legacy takes the stopped level, enhanced needs
    // the monitored axes to come to a stop while this axis waits.
    wire stop_now = stop_met(max_code, axes_i);
    wire stop_edge = stop_now & ~stop_prev_ff;
    wire stop_cond = enhanced ? stop_edge : stop_now;

    // Internal sync pulse of this axis.
    wire nxt_sync = sync_trigger(syo_code, evt_i);

    // Event vector in the cause-enable layout.
    wire [AXS_IRQ_W-1:0] evt_vec = {
        evt_i.cmp_hit,
        evt_i.decel_done,
        evt_i.decel_start,
        evt_i.accel_done,
        evt_i.accel_start,
        4'h0
    };

    // Start sequencing.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            AXS_IDLE: begin
                if (start_cmd) begin
                    case (msy_code)
                        AXS_MSY_SYNC: nxt_state = AXS_WAIT_SYNC;
                        AXS_MSY_STOP: nxt_state = AXS_WAIT_STOP;
                        default: nxt_state = AXS_RUN;
                    endcase
                end
            end
            AXS_WAIT_SYNC: begin
                if (stop_cmd) begin
                    nxt_state = AXS_IDLE;
                end else if (sync_in) begin
                    nxt_state = AXS_RUN;
                end
            end
            AXS_WAIT_STOP: begin
                if (stop_cmd) begin
                    nxt_state = AXS_IDLE;
                end else if (stop_cond) begin
                    nxt_state = AXS_RUN;
                end
            end
            AXS_RUN: begin
                if (stop_cmd | evt_i.decel_done) begin
                    nxt_state = AXS_IDLE;
                end
            end
            default: nxt_state = AXS_IDLE;
        endcase
    end

    // Operation status field shown to software.
    wire [3:0] op_status = (state_ff == AXS_WAIT_SYNC) ? AXS_ST_WSYNC :
        (state_ff == AXS_WAIT_STOP) ? AXS_ST_WSTOP :
        (state_ff == AXS_RUN) ? AXS_ST_RUN : AXS_ST_IDLE;

    // Read data; write-only and unmapped addresses read as zero.
    wire [31:0] rd_data =
        (hi_ok & (adr == AXS_ADR_EXT_STS)) ? {28'h0000000, op_status} :
        (hi_ok & (adr == AXS_ADR_IRQ_STS)) ?
            {{(32 - AXS_IRQ_W){1'b0}}, irq_sts} :
        32'h0000_0000;

    // Configuration registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            env2_ff <= AXS_RST_WORD;
            env5_ff <= AXS_RST_WORD;
            mode_ff <= AXS_RST_WORD;
            irq_en_ff <= '0;
        end else begin
            env2_ff <= wr_env2 ? env2_wr : env2_ff;
            env5_ff <= wr_env5 ? env5_wr : env5_ff;
            mode_ff <= wr_mode ? mode_wr : mode_ff;
            irq_en_ff <= nxt_irq_en;
        end
    end

    // Bus answer: ack one cycle after the request, dropped after one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= AXS_RST_WORD;
        end else begin
            ack_ff <= req;
            dat_ff <= rd ? rd_data : dat_ff;
        end
    end

    // Axis state, run level and emitted sync pulse.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= AXS_IDLE;
            run_ff <= 1'b0;
            sync_ff <= 1'b0;
            stop_prev_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            run_ff <= (nxt_state == AXS_RUN);
            sync_ff <= nxt_sync;
            stop_prev_ff <= stop_now;
        end
    end

    // Sticky event causes and the level interrupt.
    axs_irq #(
        .WIDTH(AXS_IRQ_W)
    ) u_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .event_i(evt_vec),
        .clear_i(clr_bits),
        .enable_i(irq_en_ff),
        .status_o(irq_sts),
        .irq_o(irq_line)
    );

    // Outputs, all straight from flip-flops.
    assign wb_dat_o = dat_ff;
    assign wb_ack_o = ack_ff;
    assign run_o = run_ff;
    assign sync_o = sync_ff;
    assign irq_o = irq_line;

endmodule

`default_nettype wire

// ==== verification/axs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module axs_monitor
    import axs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire axs_evt_t evt_i,
    input wire axs_axes_t axes_i,
    input wire logic run_o,
    input wire logic sync_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answers exactly one cycle after taking, for one cycle.
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_ack_cause: assert property ($rose(wb_ack_o)
        |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    // Reset silences every output on the next edge.
    chk_reset_quiet: assert property (disable iff (1'b0) rst_i
        |=> !run_o && !sync_o && !irq_o && !wb_ack_o) else $error("rst");
    // A sync pulse always follows a trigger event.
    chk_sync_cause: assert property (sync_o |-> $past(evt_i != '0))
        else $error("sync without event");
    // Running starts only from a command, a sync pulse or a stop level.
    chk_run_cause: assert property ($rose(run_o) |->
        $past(wb_cyc_i && wb_we_i) || $past(axes_i != '0))
        else $error("run without cause");
    // Interrupt rises from an event or an enable write.
    chk_irq_cause: assert property ($rose(irq_o) |->
        $past(evt_i != '0) || $past(wb_cyc_i && wb_we_i))
        else $error("irq without cause");
    chk_irq_hold: assert property (irq_o && !(wb_cyc_i && wb_we_i)
        |=> irq_o) else $error("irq dropped");
    chk_decel_stop: assert property (run_o && evt_i.decel_done
        |=> !run_o) else $error("run past decel end");
endmodule
bind axs_top axs_monitor i_axs_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .evt_i(evt_i),
    .axes_i(axes_i), .run_o(run_o), .sync_o(sync_o), .irq_o(irq_o));
`default_nettype wire

// ==== verification/axs_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// The other axis: stop levels and one-cycle sync pulses.
module axs_partner
    import axs_pkg::*;
(
    input wire logic clk_i,
    output var axs_axes_t axes_o
);
    initial axes_o = '0;
    // Changes a stop level and returns at the edge that samples it.
    task automatic set_stop(input bit y, input bit v);
        @(posedge clk_i);
        if (y) axes_o.y_stopped <= v;
        else axes_o.x_stopped <= v;
        @(posedge clk_i);
    endtask
    // Emits a sync pulse that lasts exactly one cycle.
    task automatic sync_pulse(input bit y);
        @(posedge clk_i);
        if (y) axes_o.y_sync <= 1'b1;
        else axes_o.x_sync <= 1'b1;
        @(posedge clk_i);
        axes_o.x_sync <= 1'b0;
        axes_o.y_sync <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verification/axs_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module axs_top_test
    import axs_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [3:0] sel_q = 4'hf;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    axs_evt_t evt_i = '0;
    axs_axes_t axes;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, run_o, sync_o, irq_o;
    int error_cnt = 0;
    int tests_run = 0;
    // Clock of 25 ns.
    always #12.5 clk_i = ~clk_i;
    axs_top i_axs_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .evt_i(evt_i), .axes_i(axes), .run_o(run_o),
        .sync_o(sync_o), .irq_o(irq_o));
    axs_partner i_axs_partner (.clk_i(clk_i), .axes_o(axes));
    task automatic conclude();
        $display("Checks %0d, errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // One classic cycle; holds the request until ack is sampled.
    task automatic wb(input logic [7:0] a, input logic [31:0] d,
        input logic w, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        wb_sel_i <= sel_q;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        chk("ack", 1, wb_ack_o);
        q = wb_dat_o;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, d, 1'b1, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 32'h0, 1'b0, q);
        chk("read", e, q);
    endtask
    // One-cycle event on input k; returns in the cycle after sampling.
    task automatic pulse(input int k);
        @(posedge clk_i);
        evt_i <= axs_evt_t'(9'h1 << k);
        @(posedge clk_i);
        evt_i <= '0;
        #1;
    endtask
    // Reset values, write-only and unmapped places read zero.
    task automatic t_regs();
        logic [7:0] ad [8] = '{AXS_ADR_ENV2, AXS_ADR_ENV5, AXS_ADR_MODE,
            AXS_ADR_CMD, AXS_ADR_EXT_STS, AXS_ADR_IRQ_STS, AXS_ADR_IRQ_EN,
            8'h40};
        wr(8'h40, 32'hffff_ffff);
        foreach (ad[i]) rd(ad[i], AXS_RST_WORD);
    endtask
    // Every timing code against every trigger event.
    task automatic t_sync_out();
        for (int c = 0; c < 16; c++) begin
            wr(AXS_ADR_ENV5, 32'(c) << AXS_SYO_LSB);
            for (int k = 0; k < 9; k++) begin
                pulse(k);
                chk("sync", 32'((c > 0 && c < 6 && k == c + 3) ||
                    (c > 7 && c < 12 && k == c - 8)), sync_o);
            end
        end
    endtask
    // Only the selected byte lanes of a write land.
    task automatic t_lanes();
        wr(AXS_ADR_ENV5, 32'hb << AXS_SYO_LSB);
        sel_q = 4'h3;
        wr(AXS_ADR_ENV5, 32'h0);
        sel_q = 4'hf;
        pulse(3);
        chk("sync lanes", 1, sync_o);
    endtask
    // Each cause masked, then enabled, sticky, then cleared.
    task automatic t_irq();
        int m;
        wr(AXS_ADR_IRQ_CLR, 32'h1ff0);
        wr(AXS_ADR_ENV5, 32'hb << AXS_SYO_LSB);
        for (int k = 0; k < 9; k++) begin
            m = (k + 1) % 9;
            wr(AXS_ADR_IRQ_EN, 32'h1 << (4 + k));
            pulse(m);
            chk("irq masked", 0, irq_o);
            pulse(k);
            chk("irq", 1, irq_o);
            chk("sync", 32'(k == 3), sync_o);
            rd(AXS_ADR_IRQ_STS, (32'h1 << (4 + k)) | (32'h1 << (4 + m)));
            wr(AXS_ADR_IRQ_CLR, 32'h1ff0);
            chk("irq clr", 0, irq_o);
            rd(AXS_ADR_IRQ_STS, 32'h0);
        end
    endtask
    // Start on the sync pulse of the selected axis only.
    task automatic t_sync_start();
        for (int s = 0; s < 2; s++) begin
            wr(AXS_ADR_ENV5, 32'(s) << AXS_SYI_LSB);
            wr(AXS_ADR_MODE, 32'(AXS_MSY_SYNC) << AXS_MSY_LSB);
            wr(AXS_ADR_CMD, 32'h1);
            rd(AXS_ADR_EXT_STS, 32'(AXS_ST_WSYNC));
            i_axs_partner.sync_pulse(s == 0);
            #1;
            chk("run wrong", 0, run_o);
            i_axs_partner.sync_pulse(s == 1);
            #1;
            chk("run", 1, run_o);
            wr(AXS_ADR_CMD, 32'h2);
            chk("run stop", 0, run_o);
        end
        wr(AXS_ADR_MODE, 32'h0);
        wr(AXS_ADR_CMD, 32'h1);
        chk("run imm", 1, run_o);
        pulse(3);
        chk("run decel", 0, run_o);
    endtask
    // Start on stop of X, Y or both; legacy against enhanced mode.
    task automatic t_stop_start();
        wr(AXS_ADR_ENV2, 32'h0);
        for (int m = 1; m < 4; m++) begin
            wr(AXS_ADR_MODE, 32'(m << AXS_MAX_LSB | 3 << AXS_MSY_LSB));
            wr(AXS_ADR_CMD, 32'h1);
            rd(AXS_ADR_EXT_STS, 32'(AXS_ST_WSTOP));
            i_axs_partner.set_stop(m == 1, 1'b1);
            #1;
            chk("run early", 0, run_o);
            i_axs_partner.set_stop(m != 1, 1'b1);
            #1;
            chk("run", 1, run_o);
            wr(AXS_ADR_CMD, 32'h2);
            i_axs_partner.set_stop(1'b0, 1'b0);
            i_axs_partner.set_stop(1'b1, 1'b0);
        end
        i_axs_partner.set_stop(1'b0, 1'b1);
        wr(AXS_ADR_MODE, 32'(1 << AXS_MAX_LSB | 3 << AXS_MSY_LSB));
        wr(AXS_ADR_CMD, 32'h1);
        rd(AXS_ADR_EXT_STS, 32'(AXS_ST_RUN));
        wr(AXS_ADR_CMD, 32'h2);
        wr(AXS_ADR_ENV2, 32'h1 << AXS_SMODE_BIT);
        wr(AXS_ADR_CMD, 32'h1);
        rd(AXS_ADR_EXT_STS, 32'(AXS_ST_WSTOP));
        i_axs_partner.set_stop(1'b0, 1'b0);
        i_axs_partner.set_stop(1'b0, 1'b1);
        #1;
        chk("run enh", 1, run_o);
    endtask
    // Main sequence after six reset cycles.
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_sync_out();
        t_lanes();
        t_irq();
        t_sync_start();
        t_stop_start();
        conclude();
    end
    // Watchdog well beyond the expected several hundred cycles.
    initial begin
        #1_000_000;
        error_cnt++;
        conclude();
    end
endmodule
`default_nettype wire
